// ==== testbench/soft_reset_checker.sv ====
// bus timing and unit output checks for the soft reset block
// assumes it is bound onto the top module, one clock domain
`default_nettype none
module soft_reset_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic adc_a_reset,
  input wire logic watchdog_reset,
  input wire logic gp_counter_a_reset,
  input wire logic async_serial_a_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] u;
  assign u = {adc_a_reset, watchdog_reset, gp_counter_a_reset, async_serial_a_reset};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  // units stay held through reset, registers come up clear
  chk_reset_units: assert property (
    $rose(aresetn) |-> u == 4'hF && !bvalid ##1 awready && arready && u == 4'h0)
    else $error("units or bus wrong around reset release");
  // depth 2 skips the release edge, where units legally drop
  chk_unit_cause: assert property (
    $changed(u) && $past(aresetn, 2) |-> $past(bvalid))
    else $error("unit output moved without a write");
  chk_b_latency: assert property (
    wr_take |-> ##2 bvalid)
    else $error("write response late");
  chk_r_latency: assert property (
    rd_take |-> ##2 rvalid)
    else $error("read response late");
  chk_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_ar_refused: assert property (
    rvalid |-> !arready)
    else $error("second read accepted");
  chk_rsv_zero: assert property (
    rvalid |-> (rdata & ~32'h030F507B) == 32'h0)
    else $error("reserved bit read as one");
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the peripheral soft reset block
// assumes the checker file is compiled before this one
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, capability_mask_a, capability_mask_b, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic adc_a_reset, hibernation_reset, watchdog_reset, comparator_b_reset;
  logic comparator_a_reset, gp_counter_d_reset, gp_counter_c_reset, gp_counter_b_reset;
  logic gp_counter_a_reset, two_wire_b_reset, two_wire_a_reset, sync_serial_b_reset;
  logic sync_serial_a_reset, async_serial_b_reset, async_serial_a_reset;
  int failures = 0;
  int cmp_count = 0;
  wire logic [14:0] u = {adc_a_reset, hibernation_reset, watchdog_reset,
    comparator_b_reset, comparator_a_reset, gp_counter_d_reset, gp_counter_c_reset,
    gp_counter_b_reset, gp_counter_a_reset, two_wire_b_reset, two_wire_a_reset,
    sync_serial_b_reset, sync_serial_a_reset, async_serial_b_reset, async_serial_a_reset};
  peripheral_soft_reset_control DUT (.*);
  always #4 aclk = ~aclk;
  // ready stands with the request; only valid or the watchdog ends a wait
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
    output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (bvalid) break;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    rs = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (rvalid) break;
      if (arready) arvalid <= 1'h0;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task t_reset;
    rd(12'h040, d, r);
    `CHK(d, 32'h0)
    `CHK(r, 2'h0)
    rd(12'h044, d, r);
    `CHK(d, 32'h0)
    `CHK(u, 15'h0)
  endtask
  task automatic t_units;
    int b[15] = '{16, 6, 3, 25, 24, 19, 18, 17, 16, 14, 12, 5, 4, 1, 0};
    logic [11:0] a;
    for (int i = 0; i < 15; i++) begin
      a = (i < 3) ? 12'h040 : 12'h044;
      wr(a, 32'h1 << b[i], 4'hF, r);
      `CHK(u, 15'h4000 >> i)
      rd(a, d, r);
      `CHK(d, 32'h1 << b[i])
      wr(a, 32'h0, 4'hF, r);
      `CHK(u, 15'h0)
    end
  endtask
  task t_mask;
    wr(12'h040, 32'hFFFFFFFF, 4'hF, r);
    rd(12'h040, d, r);
    `CHK(d, 32'h00010048)
    `CHK(u, 15'h7000)
    capability_mask_a <= 32'hFFFFFFBF;
    wr(12'h040, 32'h0, 4'hF, r);
    rd(12'h040, d, r);
    `CHK(d, 32'h00000040)
    capability_mask_b <= 32'hFEFFFFFF;
    wr(12'h044, 32'hFFFFFFFF, 4'hF, r);
    rd(12'h044, d, r);
    `CHK(d, 32'h020F5033)
    capability_mask_a <= 32'hFFFFFFFF;
    capability_mask_b <= 32'hFFFFFFFF;
    wr(12'h044, 32'h0, 4'h1, r);
    rd(12'h044, d, r);
    `CHK(d, 32'h020F5000)
  endtask
  task t_errors;
    rd(12'h060, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    wr(12'h050, 32'hFFFFFFFF, 4'hF, r);
    `CHK(r, 2'h2)
    wr(12'h040, 32'h8, 4'hF, r);
    `CHK(r, 2'h0)
    rd(12'h050, d, r);
    `CHK(d, 32'h8)
    rd(12'h054, d, r);
    `CHK(d, 32'h020F5001)
  endtask
  task t_rmw;
    rd(12'h044, d, r);
    wr(12'h044, d | 32'h00000001, 4'hF, r);
    rd(12'h044, d, r);
    `CHK(d, 32'h020F5001)
    `CHK(u[0], 1'h1)
  endtask
  // system reset in mid-run must clear registers left set by earlier scenarios
  task t_sysreset;
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(u, 15'h7FFF)
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(12'h040, d, r);
    `CHK(d, 32'h0)
    rd(12'h044, d, r);
    `CHK(d, 32'h0)
    `CHK(u, 15'h0)
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    wrap_up;
  end
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    capability_mask_a = 32'hFFFFFFFF;
    capability_mask_b = 32'hFFFFFFFF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_units;
    t_mask;
    t_rmw;
    t_errors;
    t_sysreset;
    wrap_up;
  end
endmodule
bind peripheral_soft_reset_control soft_reset_checker chk_i (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .rready, .rdata, .adc_a_reset, .watchdog_reset,
  .gp_counter_a_reset, .async_serial_a_reset);
`default_nettype wire

// ==== verilog/axi_lite_port.sv ====
// axi4-lite slave front end: channel handshakes, one write and one read
// assumes the register file answers wr_ok, rd_ok and rd_data combinationally
`default_nettype none
module axi_lite_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [soft_reset_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [soft_reset_pkg::DATA_W-1:0] wdata,
  input wire logic [soft_reset_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [soft_reset_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [soft_reset_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [soft_reset_pkg::ADDR_W-1:0] wr_addr,
  output logic [soft_reset_pkg::DATA_W-1:0] wr_data,
  output logic [soft_reset_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_ok,
  output logic [soft_reset_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [soft_reset_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  typedef struct packed {
    logic aw_held;
    logic [soft_reset_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [soft_reset_pkg::DATA_W-1:0] w_data;
    logic [soft_reset_pkg::STRB_W-1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_held;
    logic [soft_reset_pkg::ADDR_W-1:0] ar_addr;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [soft_reset_pkg::DATA_W-1:0] rdata;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic do_write;
  logic do_read;

  // a write goes ahead once address and data are both held
  assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign do_read = st_r.ar_held && !st_r.rvalid;
  assign wr_en = do_write;
  assign wr_addr = st_r.aw_addr;
  assign wr_data = st_r.w_data;
  assign wr_strb = st_r.w_strb;
  assign rd_addr = st_r.ar_addr;

  always_comb begin
    st_nxt = st_r;
    if (awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (do_write) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok ? soft_reset_pkg::RESP_OKAY : soft_reset_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.ar_held = 1'b1;
      st_nxt.ar_addr = araddr;
    end
    if (do_read) begin
      st_nxt.ar_held = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_ok ? rd_data : '0;
      st_nxt.rresp = rd_ok ? soft_reset_pkg::RESP_OKAY : soft_reset_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // ready stays low while a channel is held or its answer is pending
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.ar_held && !st_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rresp = st_r.rresp;
  assign rdata = st_r.rdata;
endmodule
`default_nettype wire

// ==== verilog/peripheral_soft_reset_control.sv ====
// software reset control for the on-chip peripheral units
// assumes capability masks come from the device capability registers elsewhere
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none

module peripheral_soft_reset_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [soft_reset_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [soft_reset_pkg::DATA_W-1:0] wdata,
  input wire logic [soft_reset_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [soft_reset_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [soft_reset_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  output logic adc_a_reset,
  output logic hibernation_reset,
  output logic watchdog_reset,
  output logic comparator_b_reset,
  output logic comparator_a_reset,
  output logic gp_counter_d_reset,
  output logic gp_counter_c_reset,
  output logic gp_counter_b_reset,
  output logic gp_counter_a_reset,
  output logic two_wire_b_reset,
  output logic two_wire_a_reset,
  output logic sync_serial_b_reset,
  output logic sync_serial_a_reset,
  output logic async_serial_b_reset,
  output logic async_serial_a_reset
);
  typedef struct packed {
    logic [31:0] reset_a;
    logic [31:0] reset_b;
    logic [31:0] held_a;
    logic [31:0] held_b;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic wr_en;
  logic [soft_reset_pkg::ADDR_W-1:0] wr_addr;
  logic [soft_reset_pkg::DATA_W-1:0] wr_data;
  logic [soft_reset_pkg::STRB_W-1:0] wr_strb;
  logic wr_ok;
  logic [soft_reset_pkg::ADDR_W-1:0] rd_addr;
  logic [soft_reset_pkg::DATA_W-1:0] rd_data;
  logic rd_ok;
  logic [31:0] lane_mask;
  soft_reset_pkg::reg_sel_t wr_sel;
  soft_reset_pkg::reg_sel_t rd_sel;

  // word decode shared by the write and the read path
  function automatic soft_reset_pkg::reg_sel_t decode(
    input logic [soft_reset_pkg::ADDR_W-1:0] addr
  );
    logic [soft_reset_pkg::ADDR_W-1:0] word;
    word = {addr[soft_reset_pkg::ADDR_W-1:2], 2'h0};
    case (word)
      soft_reset_pkg::OFS_RESET_A: decode = soft_reset_pkg::SEL_RESET_A;
      soft_reset_pkg::OFS_RESET_B: decode = soft_reset_pkg::SEL_RESET_B;
      soft_reset_pkg::OFS_HELD_A: decode = soft_reset_pkg::SEL_HELD_A;
      soft_reset_pkg::OFS_HELD_B: decode = soft_reset_pkg::SEL_HELD_B;
      default: decode = soft_reset_pkg::SEL_NONE;
    endcase
  endfunction

  // merge new data into the bits that a write is allowed to touch
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [31:0] allowed
  );
    merge = (old & ~allowed) | (data & allowed);
  endfunction

  axi_lite_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // byte enables widen to a bit mask, one lane per strobe
  genvar lane;
  generate
    for (lane = 0; lane < soft_reset_pkg::STRB_W; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wr_strb[lane]}};
    end
  endgenerate

  assign wr_sel = decode(wr_addr);
  assign rd_sel = decode(rd_addr);
  // status words are read-only; a write to them is answered with an error
  assign wr_ok = (wr_sel == soft_reset_pkg::SEL_RESET_A) ||
                 (wr_sel == soft_reset_pkg::SEL_RESET_B);
  assign rd_ok = (rd_sel != soft_reset_pkg::SEL_NONE);

  always_comb begin
    case (rd_sel)
      soft_reset_pkg::SEL_RESET_A: rd_data = st_r.reset_a & soft_reset_pkg::WRITABLE_A;
      soft_reset_pkg::SEL_RESET_B: rd_data = st_r.reset_b & soft_reset_pkg::WRITABLE_B;
      soft_reset_pkg::SEL_HELD_A: rd_data = st_r.held_a & soft_reset_pkg::WRITABLE_A;
      soft_reset_pkg::SEL_HELD_B: rd_data = st_r.held_b & soft_reset_pkg::WRITABLE_B;
      default: rd_data = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (wr_en && wr_sel == soft_reset_pkg::SEL_RESET_A) begin
      // absent units keep their bit; reserved bits can never be set
      st_nxt.reset_a = merge(st_r.reset_a, wr_data,
        lane_mask & capability_mask_a & soft_reset_pkg::WRITABLE_A);
    end
    if (wr_en && wr_sel == soft_reset_pkg::SEL_RESET_B) begin
      st_nxt.reset_b = merge(st_r.reset_b, wr_data,
        lane_mask & capability_mask_b & soft_reset_pkg::WRITABLE_B);
    end
    // units follow the control bits one cycle after the write lands
    st_nxt.held_a = st_r.reset_a & soft_reset_pkg::WRITABLE_A;
    st_nxt.held_b = st_r.reset_b & soft_reset_pkg::WRITABLE_B;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.reset_a <= soft_reset_pkg::RESET_A_INIT;
      st_r.reset_b <= soft_reset_pkg::RESET_B_INIT;
      // units stay in reset while the whole system is
      st_r.held_a <= soft_reset_pkg::HELD_INIT;
      st_r.held_b <= soft_reset_pkg::HELD_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign adc_a_reset = st_r.held_a[soft_reset_pkg::ADC_A_BIT];
  assign hibernation_reset = st_r.held_a[soft_reset_pkg::HIB_BIT];
  assign watchdog_reset = st_r.held_a[soft_reset_pkg::WDOG_BIT];
  assign comparator_b_reset = st_r.held_b[soft_reset_pkg::CMP_B_BIT];
  assign comparator_a_reset = st_r.held_b[soft_reset_pkg::CMP_A_BIT];
  assign gp_counter_d_reset = st_r.held_b[soft_reset_pkg::GPC_D_BIT];
  assign gp_counter_c_reset = st_r.held_b[soft_reset_pkg::GPC_C_BIT];
  assign gp_counter_b_reset = st_r.held_b[soft_reset_pkg::GPC_B_BIT];
  assign gp_counter_a_reset = st_r.held_b[soft_reset_pkg::GPC_A_BIT];
  assign two_wire_b_reset = st_r.held_b[soft_reset_pkg::TW_B_BIT];
  assign two_wire_a_reset = st_r.held_b[soft_reset_pkg::TW_A_BIT];
  assign sync_serial_b_reset = st_r.held_b[soft_reset_pkg::SS_B_BIT];
  assign sync_serial_a_reset = st_r.held_b[soft_reset_pkg::SS_A_BIT];
  assign async_serial_b_reset = st_r.held_b[soft_reset_pkg::AS_B_BIT];
  assign async_serial_a_reset = st_r.held_b[soft_reset_pkg::AS_A_BIT];
endmodule
`default_nettype wire

// ==== verilog/soft_reset_pkg.sv ====
// constants for the peripheral soft reset control block
// assumes a 32-bit axi4-lite register bus and one system clock
`default_nettype none
package soft_reset_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  // register byte offsets
  localparam logic [11:0] OFS_RESET_A = 12'h040;
  localparam logic [11:0] OFS_RESET_B = 12'h044;
  localparam logic [11:0] OFS_HELD_A = 12'h050;
  localparam logic [11:0] OFS_HELD_B = 12'h054;
  localparam logic [31:0] RESET_A_INIT = 32'h00000000;
  localparam logic [31:0] RESET_B_INIT = 32'h00000000;
  // bits that name a unit; all others read as zero
  localparam logic [31:0] WRITABLE_A = 32'h00010048;
  localparam logic [31:0] WRITABLE_B = 32'h030F5033;
  // unit level while the system reset is applied
  localparam logic [31:0] HELD_INIT = 32'hFFFFFFFF;
  // bit positions in the first register
  localparam int ADC_A_BIT = 16;
  localparam int HIB_BIT = 6;
  localparam int WDOG_BIT = 3;
  // bit positions in the second register
  localparam int CMP_B_BIT = 25;
  localparam int CMP_A_BIT = 24;
  localparam int GPC_D_BIT = 19;
  localparam int GPC_C_BIT = 18;
  localparam int GPC_B_BIT = 17;
  localparam int GPC_A_BIT = 16;
  localparam int TW_B_BIT = 14;
  localparam int TW_A_BIT = 12;
  localparam int SS_B_BIT = 5;
  localparam int SS_A_BIT = 4;
  localparam int AS_B_BIT = 1;
  localparam int AS_A_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {SEL_RESET_A, SEL_RESET_B, SEL_HELD_A, SEL_HELD_B, SEL_NONE} reg_sel_t;
endpackage
`default_nettype wire
